/* File: hdl/cdcg_top.sv */
// Drive clock generator: register slave, generators, output select and PWM stage
`timescale 1ns/1ps

// Functional notes
// (RQ1) The input select bit feeds the generators with half the crystal clock at 0, full at 1.
// (RQ2) Bit 7 enables the synthesizer and bit 6 the fixed generator, each independently.
// (RQ3) The synthesizer covers 100 kHz to 220 kHz in 0.1 kHz steps.
// (RQ4) The fixed generator runs at 1 MHz whenever it is enabled.
// (RQ5) The output select bit routes the synthesizer at 0 and the 1 MHz generator at 1.
// (RQ6) An 11-bit code split over two registers gives 100 kHz plus code times 0.1 kHz.
// (RQ7) Codes above 1200 give 220 kHz.
// (RQ8) The selected generator output is the drive from which the PWM pins are derived.
// (RQ9) Bits 3..0 of the PWM control register each enable one PWM output.
// (RQ10) Mode pattern 0101 is plain mode and 1010 is complementary bridge mode with dead time.
// (RQ11) Writing any other mode pattern requests a full controller reset.
// (RQ12) The PWM control register resets to mode 0101 with all channels disabled.
// (RQ13) The write-protect bit blocks writes to the PWM control and dead-time fields when set.
// (RQ14) The dead-time prescaler divides the high-speed clock by 1, 2, 4 or 8.
// (RQ15) Dead time is (code+1) prescaled periods minus one high-speed clock period.
// (RQ16) Disabled channels stay low and a disabled generator makes no transitions.
module cdcg_top
    import cdcg_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Drive outputs
    output logic [3:0]       pwm_o,
    output logic             gen_out_o,
    // System
    output logic             mcu_reset_req_o
);

    // Registers
    logic [7:0]  gen_ctrl_q;
    logic [7:0]  freq_lo_q;
    logic [2:0]  freq_hi_q;
    logic [7:0]  pwm_ctrl_q;
    logic [7:0]  dt_ctrl_q;

    // Bus handshake
    logic        bus_req;
    logic        wr_go;
    logic [7:0]  wr_byte;
    logic [31:0] rd_data;
    logic        wprot;

    // Generators
    logic        half_tick_q;
    logic        tick;
    logic        synth_out;
    logic [6:0]  fix_cnt_q;
    logic [6:0]  fix_half;
    logic        fix_out_q;
    logic        drive_n;

    // Dead time
    logic        drive_q;
    logic [5:0]  dt_cnt_q;
    logic [5:0]  dt_cnt_d;
    logic        compl_mode;
    logic [3:0]  pwm_d;

    // Dead time in clock cycles: ((k+1) << psc) - 1
    function automatic logic [5:0] dt_cycles(input logic [2:0] k, input logic [1:0] psc);
        logic [6:0] periods;
        periods = 7'({4'h0, k} + 7'h01) << psc;                          // [RQ14]
        return 6'(periods - 7'h01);                                      // [RQ15]
    endfunction

    // ---------------- Avalon-MM slave ----------------

    // One wait cycle, then a single cycle with waitrequest low
    assign bus_req = avs_read_i | avs_write_i;
    assign wr_go   = avs_write_i & ~avs_waitrequest_o & avs_byteenable_i[0];
    assign wr_byte = avs_writedata_i[7:0];
    assign wprot   = dt_ctrl_q[CDCG_BIT_WPROT];

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else if (bus_req && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    always_comb begin
        rd_data = 32'h00000000;
        case (avs_address_i)
            CDCG_OFS_GEN_CTRL: rd_data[7:0] = gen_ctrl_q;
            CDCG_OFS_FREQ_LO:  rd_data[7:0] = freq_lo_q;
            CDCG_OFS_FREQ_HI:  rd_data[2:0] = freq_hi_q;
            CDCG_OFS_PWM_CTRL: rd_data[7:0] = pwm_ctrl_q;
            CDCG_OFS_DT_CTRL:  rd_data[7:0] = dt_ctrl_q;
            CDCG_OFS_STATUS:   rd_data[7:0] = {pwm_o, gen_out_o, fix_out_q, synth_out, drive_q};
            default:           rd_data = 32'h00000000;
        endcase
    end

    // Read data is valid in the cycle waitrequest is low
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            avs_readdata_o <= 32'h00000000;
        end else if (avs_read_i && avs_waitrequest_o) begin
            avs_readdata_o <= rd_data;
        end
    end

    // ---------------- Register file ----------------

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            gen_ctrl_q <= CDCG_RST_GEN_CTRL;
        end else if (wr_go && avs_address_i == CDCG_OFS_GEN_CTRL) begin
            gen_ctrl_q <= {wr_byte[7:4], 4'h0};                          // [RQ2]
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            freq_lo_q <= CDCG_RST_FREQ_LO;
            freq_hi_q <= CDCG_RST_FREQ_HI;
        end else if (wr_go && avs_address_i == CDCG_OFS_FREQ_LO) begin
            freq_lo_q <= wr_byte;                                        // [RQ6]
        end else if (wr_go && avs_address_i == CDCG_OFS_FREQ_HI) begin
            freq_hi_q <= wr_byte[2:0];                                   // [RQ6]
        end
    end

    // Bad mode patterns are not stored; they only raise the reset request
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pwm_ctrl_q <= CDCG_RST_PWM_CTRL;                             // [RQ12]
        end else if (wr_go && !wprot && avs_address_i == CDCG_OFS_PWM_CTRL) begin // [RQ13]
            if (wr_byte[7:4] == CDCG_MODE_PLAIN || wr_byte[7:4] == CDCG_MODE_COMPL) begin
                pwm_ctrl_q <= wr_byte;                                   // [RQ10]
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mcu_reset_req_o <= 1'b0;
        end else begin
            mcu_reset_req_o <= wr_go && !wprot && avs_address_i == CDCG_OFS_PWM_CTRL
                               && wr_byte[7:4] != CDCG_MODE_PLAIN
                               && wr_byte[7:4] != CDCG_MODE_COMPL;       // [RQ11]
        end
    end

    // Protect bit itself stays writable so software can unlock
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dt_ctrl_q <= CDCG_RST_DT_CTRL;
        end else if (wr_go && avs_address_i == CDCG_OFS_DT_CTRL) begin
            dt_ctrl_q[CDCG_BIT_WPROT] <= wr_byte[CDCG_BIT_WPROT];
            if (!wprot) begin
                dt_ctrl_q[4:0] <= wr_byte[4:0];                          // [RQ13]
            end
        end
    end

    // ---------------- Generators ----------------

    // Half-rate tick alternates; full rate ticks every cycle
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            half_tick_q <= 1'b0;
        end else begin
            half_tick_q <= ~half_tick_q;
        end
    end

    assign tick = gen_ctrl_q[CDCG_BIT_IN_SEL] | half_tick_q;             // [RQ1]

    cdcg_synth u_synth (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .tick_i (tick),
        .half_i (~gen_ctrl_q[CDCG_BIT_IN_SEL]),
        .en_i   (gen_ctrl_q[CDCG_BIT_SYNTH_EN]),                         // [RQ2]
        .code_i ({freq_hi_q, freq_lo_q}),
        .out_o  (synth_out)
    );

    // Half period counts halve when ticks come at half rate
    assign fix_half = gen_ctrl_q[CDCG_BIT_IN_SEL] ? CDCG_FIXED_HALF : {1'b0, CDCG_FIXED_HALF[6:1]};

    always_ff @(posedge clk_i) begin
        if (srst_i || !gen_ctrl_q[CDCG_BIT_FIXED_EN]) begin
            fix_cnt_q <= 7'h00;                                          // [RQ16]
            fix_out_q <= 1'b0;
        end else if (tick) begin
            if (fix_cnt_q >= fix_half - 7'h01) begin
                fix_cnt_q <= 7'h00;
                fix_out_q <= ~fix_out_q;                                 // [RQ4]
            end else begin
                fix_cnt_q <= fix_cnt_q + 7'h01;
            end
        end
    end

    assign drive_n = gen_ctrl_q[CDCG_BIT_OUT_SEL] ? fix_out_q : synth_out; // [RQ5]

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            gen_out_o <= 1'b0;
        end else begin
            gen_out_o <= drive_n;
        end
    end

    // ---------------- PWM stage ----------------

    assign compl_mode = pwm_ctrl_q[7:4] == CDCG_MODE_COMPL;

    // Dead-time counter reloads on every drive edge in complementary mode; both sides idle while it runs
    always_comb begin
        if (drive_n != drive_q && compl_mode) begin
            dt_cnt_d = dt_cycles(dt_ctrl_q[2:0], dt_ctrl_q[4:3]);        // [RQ15]
        end else if (dt_cnt_q != 6'h00) begin
            dt_cnt_d = dt_cnt_q - 6'h01;
        end else begin
            dt_cnt_d = 6'h00;
        end
        if (compl_mode) begin
            pwm_d[0] = drive_n & (dt_cnt_d == 6'h00);                    // [RQ10]
            pwm_d[1] = ~drive_n & (dt_cnt_d == 6'h00);
        end else begin
            pwm_d[0] = drive_n;                                          // [RQ8]
            pwm_d[1] = ~drive_n;
        end
        pwm_d[2] = pwm_d[0];
        pwm_d[3] = pwm_d[1];
        pwm_d    = pwm_d & pwm_ctrl_q[3:0];                              // [RQ9] [RQ16]
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            drive_q  <= 1'b0;
            dt_cnt_q <= 6'h00;
            pwm_o    <= 4'h0;
        end else begin
            drive_q  <= drive_n;
            dt_cnt_q <= dt_cnt_d;
            pwm_o    <= pwm_d;
        end
    end

endmodule : cdcg_top

/* File: shared/cdcg_pkg.sv */
// Register map, field layout, reset values and timing constants of the drive clock generator
package cdcg_pkg;

    // Register byte offsets (word aligned)
    localparam logic [4:0] CDCG_OFS_GEN_CTRL  = 5'h00;
    localparam logic [4:0] CDCG_OFS_FREQ_LO   = 5'h04;
    localparam logic [4:0] CDCG_OFS_FREQ_HI   = 5'h08;
    localparam logic [4:0] CDCG_OFS_PWM_CTRL  = 5'h0C;
    localparam logic [4:0] CDCG_OFS_DT_CTRL   = 5'h10;
    localparam logic [4:0] CDCG_OFS_STATUS    = 5'h14;

    // generator_control fields
    localparam int CDCG_BIT_SYNTH_EN   = 7;
    localparam int CDCG_BIT_FIXED_EN   = 6;
    localparam int CDCG_BIT_OUT_SEL    = 5;
    localparam int CDCG_BIT_IN_SEL     = 4;

    // pwm_output_control fields
    localparam int CDCG_MODE_LSB       = 4;
    localparam logic [3:0] CDCG_MODE_PLAIN = 4'h5;
    localparam logic [3:0] CDCG_MODE_COMPL = 4'hA;

    // dead_time_protect_control fields
    localparam int CDCG_BIT_WPROT      = 7;
    localparam int CDCG_PSC_LSB        = 3;
    localparam int CDCG_DT_LSB         = 0;

    // Reset values
    localparam logic [7:0] CDCG_RST_GEN_CTRL = 8'h00;
    localparam logic [7:0] CDCG_RST_FREQ_LO  = 8'h00;
    localparam logic [2:0] CDCG_RST_FREQ_HI  = 3'h0;
    localparam logic [7:0] CDCG_RST_PWM_CTRL = 8'h50;
    localparam logic [7:0] CDCG_RST_DT_CTRL  = 8'h00;

    // Synthesizer: frequency in units of 0.1 kHz, accumulator modulus at full clock
    localparam int          CDCG_CLK_HZ      = 100_000_000;
    localparam int          CDCG_STEP_HZ     = 100;
    localparam logic [12:0] CDCG_BASE_UNITS  = 13'h3E8;          // 100 kHz
    localparam logic [10:0] CDCG_CODE_MAX    = 11'h4B0;          // 1200 -> 220 kHz
    localparam logic [19:0] CDCG_ACC_MOD     = 20'(CDCG_CLK_HZ / CDCG_STEP_HZ);

    // Fixed generator: 1 MHz, half period in full-rate ticks
    localparam int          CDCG_FIXED_HZ    = 1_000_000;
    localparam logic [6:0]  CDCG_FIXED_HALF  = 7'(CDCG_CLK_HZ / (2 * CDCG_FIXED_HZ));

endpackage : cdcg_pkg

/* File: hdl/cdcg_synth.sv */
// Phase-accumulator synthesizer for the 100 kHz to 220 kHz generator
`timescale 1ns/1ps

module cdcg_synth
    import cdcg_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // Control
    input  wire logic        tick_i,
    input  wire logic        half_i,
    input  wire logic        en_i,
    input  wire logic [10:0] code_i,
    // Output
    output logic             out_o
);

    logic [10:0] code_lim;
    logic [12:0] units;
    logic [13:0] step;
    logic [20:0] acc_sum;
    logic [19:0] acc_q;
    logic [19:0] acc_d;

    always_comb begin
        code_lim = (code_i > CDCG_CODE_MAX) ? CDCG_CODE_MAX : code_i;   // [RQ7]
        units    = CDCG_BASE_UNITS + {2'b00, code_lim};                  // [RQ3] [RQ6]
        // Half-rate ticks take double steps so the frequency is unchanged
        step     = half_i ? {units, 1'b0} : {1'b0, units};
        acc_sum  = {1'b0, acc_q} + {7'h00, step};
        acc_d    = (acc_sum >= {1'b0, CDCG_ACC_MOD}) ?
                   20'(acc_sum - {1'b0, CDCG_ACC_MOD}) : acc_sum[19:0];
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || !en_i) begin
            acc_q <= 20'h00000;                                          // [RQ16]
        end else if (tick_i) begin
            acc_q <= acc_d;
        end
    end

    // Square wave: high in the lower half of the phase circle
    always_ff @(posedge clk_i) begin
        if (srst_i || !en_i) begin
            out_o <= 1'b0;
        end else begin
            out_o <= (acc_q < {1'b0, CDCG_ACC_MOD[19:1]});
        end
    end

endmodule : cdcg_synth

/* File: sim/cdcg_properties.sv */
// Bus handshake, pulse and pin relations of the drive clock generator
`timescale 1ns/1ps
module cdcg_checker
    import cdcg_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic [4:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [3:0]  pwm_o,
    input wire logic        gen_out_o,
    input wire logic        mcu_reset_req_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    property p_answer;
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    property p_one_wait;
        !avs_waitrequest_o |=> avs_waitrequest_o;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("answer longer than one cycle");
    property p_idle;
        !avs_read_i && !avs_write_i |=> avs_waitrequest_o;
    endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_rdata;
        $changed(avs_readdata_o) |-> !avs_waitrequest_o && avs_read_i
            && avs_readdata_o[31:8] == 24'h0;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data moved outside answer");
    property p_rst_pulse;
        mcu_reset_req_o |=> !mcu_reset_req_o;
    endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("reset request too long");
    property p_rst_cause;
        mcu_reset_req_o |->
            $past(avs_write_i && !avs_waitrequest_o && avs_address_i == CDCG_OFS_PWM_CTRL)
            || $past(avs_write_i && !avs_waitrequest_o && avs_address_i == CDCG_OFS_PWM_CTRL, 2);
    endproperty
    a_rst_cause: assert property (p_rst_cause) else $error("reset request without write");
    property p_legs;
        !(pwm_o[0] && pwm_o[1]) && !(pwm_o[2] && pwm_o[3]);
    endproperty
    a_legs: assert property (p_legs) else $error("both legs high");
    // Checked across reset, so reset itself must not disable it
    property p_rst_vals;
        disable iff (1'b0) srst_i |=> pwm_o == 4'h0 && !gen_out_o && !mcu_reset_req_o;
    endproperty
    a_rst_vals: assert property (p_rst_vals) else $error("outputs not idle in reset");
endmodule // cdcg_checker

bind cdcg_top cdcg_checker chk_u (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .pwm_o(pwm_o), .gen_out_o(gen_out_o),
    .mcu_reset_req_o(mcu_reset_req_o));

/* File: sim/cdcg_bridge_model.sv */
// Full-bridge power stage: counts leg-0 pulses, latches any shoot-through
`timescale 1ns/1ps
module cdcg_bridge_model (
    input  wire logic       clk_i,
    input  wire logic [3:0] pwm_i,
    output int              rise_cnt_o,
    output logic            shoot_o
);
    logic prev_q = 1'b0;
    initial rise_cnt_o = 0;
    initial shoot_o = 1'b0;
    always @(posedge clk_i) begin
        prev_q <= pwm_i[0];
        if (pwm_i[0] === 1'b1 && prev_q === 1'b0) begin
            rise_cnt_o <= rise_cnt_o + 1;
        end
        // A real stage burns with both switches of one leg on
        if ((pwm_i[0] & pwm_i[1]) === 1'b1 || (pwm_i[2] & pwm_i[3]) === 1'b1) begin
            shoot_o <= 1'b1;
        end
    end
endmodule // cdcg_bridge_model

/* File: sim/cdcg_top_tb.sv */
// Self-checking bench of the drive clock generator
`timescale 1ns/1ps
module cdcg_top_tb;
    import cdcg_pkg::*;
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic [4:0]  adr = 5'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [3:0]  be = 4'hF;
    logic [31:0] rdat;
    logic        wreq;
    logic [3:0]  pwm;
    logic        gen;
    logic        rst_req;
    logic        shoot;
    logic [7:0]  v;
    int          rises;
    int          pulses = 0;
    int          errors = 0;
    int          n_compared = 0;
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) if (rst_req === 1'b1) pulses++;
    cdcg_top dut_u (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .pwm_o(pwm), .gen_out_o(gen), .mcu_reset_req_o(rst_req));
    cdcg_bridge_model model_u (.clk_i(clk_i), .pwm_i(pwm), .rise_cnt_o(rises), .shoot_o(shoot));
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // Holds the request until waitrequest is sampled low
    task automatic bus(logic w, logic [4:0] a, logic [7:0] d, logic [3:0] b = 4'hF);
        @(posedge clk_i);
        adr <= a;
        rd <= !w;
        wr <= w;
        wdat <= {24'h0, d};
        be <= b;
        do @(posedge clk_i); while (wreq !== 1'b0);
        v = rdat[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rchk(logic [4:0] a, logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk("register", v, exp);
    endtask
    task automatic span(int n, int lo, int hi);
        realtime t0;
        int      c;
        @(posedge gen);
        t0 = $realtime;
        repeat (n) @(posedge gen);
        c = int'(($realtime - t0) / 10.0);
        chk("period", c >= lo && c <= hi, 1);
    endtask
    task automatic t_regs();
        rchk(CDCG_OFS_PWM_CTRL, CDCG_RST_PWM_CTRL);
        rchk(CDCG_OFS_GEN_CTRL, CDCG_RST_GEN_CTRL);
        rchk(CDCG_OFS_DT_CTRL, CDCG_RST_DT_CTRL);
        rchk(5'h18, 8'h00);
        bus(1'b1, CDCG_OFS_GEN_CTRL, 8'hFF);
        rchk(CDCG_OFS_GEN_CTRL, 8'hF0);
        bus(1'b1, CDCG_OFS_GEN_CTRL, 8'h00, 4'h0);
        rchk(CDCG_OFS_GEN_CTRL, 8'hF0);
        bus(1'b1, CDCG_OFS_FREQ_HI, 8'hFF);
        rchk(CDCG_OFS_FREQ_HI, 8'h07);
    endtask
    task automatic t_fixed();
        int r0;
        bus(1'b1, CDCG_OFS_PWM_CTRL, 8'h55);
        bus(1'b1, CDCG_OFS_GEN_CTRL, 8'h70);
        span(4, 400, 400);
        chk("idle channels", pwm & 4'hA, 4'h0);
        bus(1'b1, CDCG_OFS_GEN_CTRL, 8'h60);
        span(4, 400, 400);
        r0 = rises;
        bus(1'b1, CDCG_OFS_GEN_CTRL, 8'hA0);
        repeat (300) @(posedge clk_i);
        chk("stopped drive", rises - r0 <= 1, 1);
        chk("stopped gen", gen, 1'b0);
    endtask
    task automatic t_synth();
        bus(1'b1, CDCG_OFS_GEN_CTRL, 8'h90);
        bus(1'b1, CDCG_OFS_FREQ_HI, 8'h00);
        bus(1'b1, CDCG_OFS_FREQ_LO, 8'h00);
        span(2, 1999, 2001);
        bus(1'b1, CDCG_OFS_FREQ_HI, 8'h01);
        bus(1'b1, CDCG_OFS_FREQ_LO, 8'h90);
        span(7, 4999, 5001);
        bus(1'b1, CDCG_OFS_FREQ_HI, 8'h04);
        bus(1'b1, CDCG_OFS_FREQ_LO, 8'hB0);
        span(11, 4999, 5001);
        bus(1'b1, CDCG_OFS_GEN_CTRL, 8'h80);
        span(11, 4999, 5001);
        bus(1'b1, CDCG_OFS_FREQ_HI, 8'h07);
        bus(1'b1, CDCG_OFS_FREQ_LO, 8'hFF);
        span(11, 4999, 5001);
    endtask
    task automatic t_mode();
        logic [7:0] exp;
        int p0;
        exp = 8'h55;
        for (int m = 0; m < 16; m++) begin
            p0 = pulses;
            bus(1'b1, CDCG_OFS_PWM_CTRL, {m[3:0], 4'h3});
            repeat (3) @(posedge clk_i);
            if (m == 5 || m == 10) exp = {m[3:0], 4'h3};
            chk("reset pulse", pulses - p0, (m == 5 || m == 10) ? 0 : 1);
            rchk(CDCG_OFS_PWM_CTRL, exp);
        end
    endtask
    task automatic t_dead();
        logic [7:0] dt[4] = '{8'h00, 8'h0A, 8'h17, 8'h1C};
        int dexp[4] = '{0, 5, 31, 39};
        int n;
        bus(1'b1, CDCG_OFS_GEN_CTRL, 8'h70);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, CDCG_OFS_DT_CTRL, dt[i]);
            wait (pwm[1] === 1'b1);
            wait (pwm[1] === 1'b0);
            n = 0;
            while (pwm[0] !== 1'b1) begin
                @(posedge clk_i);
                #1;
                n++;
            end
            chk("dead time", n, dexp[i]);
        end
        chk("shoot through", shoot, 1'b0);
    endtask
    task automatic t_protect();
        int p0;
        bus(1'b1, CDCG_OFS_DT_CTRL, 8'h00);
        bus(1'b1, CDCG_OFS_DT_CTRL, 8'h80);
        bus(1'b1, CDCG_OFS_DT_CTRL, 8'h9F);
        rchk(CDCG_OFS_DT_CTRL, 8'h80);
        p0 = pulses;
        bus(1'b1, CDCG_OFS_PWM_CTRL, 8'h5F);
        bus(1'b1, CDCG_OFS_PWM_CTRL, 8'h33);
        repeat (3) @(posedge clk_i);
        chk("protected pulse", pulses - p0, 0);
        rchk(CDCG_OFS_PWM_CTRL, 8'hA3);
        bus(1'b1, CDCG_OFS_DT_CTRL, 8'h00);
        bus(1'b1, CDCG_OFS_PWM_CTRL, 8'h5F);
        rchk(CDCG_OFS_PWM_CTRL, 8'h5F);
    endtask
    task automatic final_report();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        // About 30k cycles of tests; margin without exceeding the run budget
        #500us;
        errors++;
        final_report();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        srst_i <= 1'b0;
        t_regs();
        t_fixed();
        t_synth();
        t_mode();
        t_dead();
        t_protect();
        final_report();
    end
endmodule // cdcg_top_tb
